// ===== dv/sgs_checker.sv
// Assertion checker for the gain-switching selector ports.
module sgs_checker (
    // Clock and reset.
    input wire logic                aclk,
    input wire logic                aresetn,
    // Write channels.
    input wire logic [7:0]          s_axi_awaddr,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic [31:0]         s_axi_wdata,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    // Read channels.
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    // Loop side.
    input wire logic                ctrl_gain_cmd,
    input wire sgs_pkg::sgs_gains_s eff_gains,
    input wire logic                switch_active_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    import sgs_pkg::*;
    logic [7:0] aw_q;
    logic [7:0] wd_q;
    logic [7:0] sel_q;
    wire        sel_off = (sel_q[3:0] == 4'h0) || (sel_q[3:0] > 4'h4);
    // Shadow of the source selection, taken when its write completes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q  <= 8'h00;
            wd_q  <= 8'h00;
            sel_q <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
            if ($rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY && aw_q == OFS_SELECT) sel_q <= wd_q;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wboth;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_quiet;
        !s_axi_bvalid && $stable(sel_q);
    endsequence
    property p_off; sel_off ##0 s_quiet |-> !switch_active_reg; endproperty
    property p_cmd;
        sel_q[3:0] == 4'h1 ##0 s_quiet
            |=> switch_active_reg == ($past(ctrl_gain_cmd) ^ $past(sel_q[4]));
    endproperty
    property p_rst;
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && eff_gains == '0 && !switch_active_reg;
    endproperty
    property p_wlat; s_wboth |-> ##2 s_axi_bvalid; endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
    property p_rhi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_off: assert property (p_off) else $error("switching active with source off");
    a_cmd: assert property (p_cmd) else $error("command polarity not followed");
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    a_wlat: assert property (p_wlat) else $error("write response late");
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    a_rlat: assert property (p_rlat) else $error("read data late");
    a_arblk: assert property (p_arblk) else $error("read address taken while busy");
    a_rhi: assert property (p_rhi) else $error("upper read half not zero");
endmodule // sgs_checker

bind sgs_top sgs_checker sgs_checker_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .ctrl_gain_cmd, .eff_gains, .switch_active_reg
);

// ===== dv/sgs_host_model.sv
// Behavioural model of the motion controller that issues gain-change commands.
module sgs_host_model (
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Scenario request and motor state.
    input  wire logic        want_cmd,
    input  wire logic [31:0] motor_speed,
    // Command to the selector.
    output logic             ctrl_gain_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    // A new command level is only issued while the motor stands still.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_gain_cmd <= 1'b0;
        end else if (motor_speed == 32'h0000_0000) begin
            ctrl_gain_cmd <= want_cmd;
        end
    end
endmodule // sgs_host_model

// ===== dv/tb_top.sv
// Self-checking bench for the gain-switching selector.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sgs_pkg::*;
    localparam int unsigned CPM = 160;
    localparam sgs_gains_s GB = {16'h0010, 16'h0020, 16'h0030, 16'h0040, 16'h0050, 16'h0060};
    localparam sgs_gains_s GA = {16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0200, 16'h0300};
    localparam sgs_gains_s GM = {16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0050, 16'h0060};
    localparam logic [15:0] RTAB [10] = '{16'h0000, 16'h000A, 16'h0001, 16'h0046, 16'h0025,
                                          16'h0337, 16'h0151, 16'h03E8, 16'h03E8, 16'h0000};
    logic        aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, ctrl_gain_cmd, switch_active_reg, on;
    logic        aresetn = 1'b0, want_cmd = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] cmd_freq = 32'h0, droop_pulses = 32'h0, motor_speed = 32'h0;
    sgs_gains_s  base_gains = GB;
    sgs_gains_s  eff_gains;
    int          err_total = 0, num_checks = 0, n;

    sgs_top #(.CYC_PER_MS(CPM)) sgs_top_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ctrl_gain_cmd, .cmd_freq, .droop_pulses, .motor_speed,
        .base_gains, .eff_gains, .switch_active_reg
    );
    sgs_host_model sgs_host_model_i (.aclk, .aresetn, .want_cmd, .motor_speed, .ctrl_gain_cmd);

    task automatic close_out();
        if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [95:0] e, input logic [95:0] g);
        num_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    // The master raises bready late so that the response has to stand.
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        int k;
        @(posedge aclk);
        k = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {16'hA5A5, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        forever begin
            @(posedge aclk);
            k++;
            if (s_axi_bvalid && s_axi_bready || k > 50) break;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (k > 2) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        cmp($sformatf("bwait@%h", a), 96'(0), 96'(k > 50));
        cmp($sformatf("bresp@%h", a), 96'(er), 96'(s_axi_bresp));
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
        int k;
        @(posedge aclk);
        k = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            k++;
            if (s_axi_rvalid && s_axi_rready || k > 50) break;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (k > 1) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        cmp($sformatf("rwait@%h", a), 96'(0), 96'(k > 50));
        cmp($sformatf("rdata@%h", a), 96'({16'h0000, e}), 96'(s_axi_rdata));
        cmp($sformatf("rresp@%h", a), 96'(er), 96'(s_axi_rresp));
    endtask
    task automatic wrc(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
        wr(a, d, RESP_OKAY);
        rdc(a, e, RESP_OKAY);
    endtask
    task automatic gchk(input string nm, input logic [95:0] e);
        repeat (4) @(posedge aclk);
        cmp(nm, e, eff_gains);
    endtask

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 10; i++) rdc(8'(4 * i), RTAB[i], RESP_OKAY);
        rdc(8'h40, 16'h0000, RESP_SLVERR);
        wr(8'h28, 16'h0001, RESP_SLVERR);
        wrc(8'h04, 16'hFFFF, 16'h270F);
        wrc(8'h08, 16'h00C8, 16'h0064);
        wrc(8'h10, 16'h0000, 16'h0001);
        wrc(8'h14, 16'h0005, 16'h0014);
        wrc(8'h18, 16'h0000, 16'h0001);
        wrc(8'h1C, 16'hFFFF, 16'h03E8);
        wrc(8'h20, 16'h0000, 16'h0001);
        wrc(8'h08, 16'h0000, 16'h0000);
        wrc(8'h24, 16'h0023, 16'h0023);
        wrc(8'h0C, 16'h0100, 16'h0100);
        wrc(8'h10, 16'h0200, 16'h0200);
        wrc(8'h14, 16'h0300, 16'h0300);
        wrc(8'h18, 16'h0400, 16'h0400);
        wrc(8'h1C, 16'h0200, 16'h0200);
        wrc(8'h20, 16'h0300, 16'h0300);
        wrc(8'h04, 16'h0064, 16'h0064);
        wr(8'h00, 16'h0001, RESP_OKAY);
        want_cmd <= 1'b1;
        gchk("cmd on", GA);
        want_cmd <= 1'b0;
        gchk("cmd off", GB);
        wr(8'h00, 16'h0011, RESP_OKAY);
        gchk("cmd off inverted", GA);
        want_cmd <= 1'b1;
        gchk("cmd on inverted", GB);
        wr(8'h00, 16'h0000, RESP_OKAY);
        gchk("source off", GB);
        wr(8'h00, 16'h0005, RESP_OKAY);
        gchk("source reserved", GB);
        wr(8'h00, 16'h0001, RESP_OKAY);
        wr(8'h24, 16'h0020, RESP_OKAY);
        gchk("auto tuning", {GB[95:32], GA[31:0]});
        wr(8'h24, 16'h0003, RESP_OKAY);
        gchk("vib tuning", {GA[95:32], GB[31:0]});
        wr(8'h24, 16'h0123, RESP_OKAY);
        gchk("speed mode", {GA[95:80], GB[79:64], GA[63:32], GB[31:0]});
        wr(8'h24, 16'h0023, RESP_OKAY);
        want_cmd <= 1'b0;
        // Each measured source is probed just below, at and just above the threshold.
        for (int s = 2; s < 5; s++) begin
            for (int p = 0; p < 2; p++) begin
                wr(8'h00, 16'(s + 16 * p), RESP_OKAY);
                for (int v = 99; v < 102; v++) begin
                    cmd_freq     <= (s == 2) ? 32'(v) : 32'h0;
                    droop_pulses <= (s == 3) ? 32'(v) : 32'h0;
                    motor_speed  <= (s == 4) ? 32'(v) : 32'h0;
                    on = (p == 0) ? (v >= 100) : (v <= 100);
                    gchk("measured", on ? GM : GB);
                    cmp("switch_active", 96'(on), 96'(switch_active_reg));
                end
            end
        end
        motor_speed <= 32'h0;
        wr(8'h00, 16'h0001, RESP_OKAY);
        want_cmd <= 1'b1;
        gchk("cmd step", GA);
        rdc(8'h28, 16'h0003, RESP_OKAY);
        wr(8'h08, 16'h0001, RESP_OKAY);
        want_cmd <= 1'b0;
        n = 0;
        while (eff_gains !== GB && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        cmp("blend cycles", 96'(1), 96'(n > 150 && n < 3000));
        close_out();
    end
endmodule // tb_top

// ===== rtl/sgs_pkg.sv
// Package of constants, types and helpers for the servo gain-switching selector.
package sgs_pkg;

    // Clock rate and the time base of the gain-change time constant.
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned TC_UNIT_US    = 1000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1_000_000 * TC_UNIT_US;
    // The blend moves one 1/16 of the remaining distance per step.
    localparam int unsigned SMOOTH_SHIFT  = 4;

    // Register byte offsets.
    localparam logic [7:0] OFS_SELECT     = 8'h00;
    localparam logic [7:0] OFS_THRESHOLD  = 8'h04;
    localparam logic [7:0] OFS_TIME_CONST = 8'h08;
    localparam logic [7:0] OFS_ALT_INERT  = 8'h0C;
    localparam logic [7:0] OFS_ALT_POS    = 8'h10;
    localparam logic [7:0] OFS_ALT_SPEED  = 8'h14;
    localparam logic [7:0] OFS_ALT_INTEG  = 8'h18;
    localparam logic [7:0] OFS_ALT_VIB    = 8'h1C;
    localparam logic [7:0] OFS_ALT_RES    = 8'h20;
    localparam logic [7:0] OFS_MODE       = 8'h24;
    localparam logic [7:0] OFS_STATUS     = 8'h28;

    // Values after reset (inertia in 0.1 steps, integral in 0.1 ms, frequencies in 0.1 Hz).
    localparam logic [15:0] RST_SELECT    = 16'h0000;
    localparam logic [15:0] RST_THRESHOLD = 16'h000A;
    localparam logic [15:0] RST_TIME      = 16'h0001;
    localparam logic [15:0] RST_INERT     = 16'h0046;
    localparam logic [15:0] RST_POS       = 16'h0025;
    localparam logic [15:0] RST_SPEED     = 16'h0337;
    localparam logic [15:0] RST_INTEG     = 16'h0151;
    localparam logic [15:0] RST_VIB       = 16'h03E8;
    localparam logic [15:0] RST_RES       = 16'h03E8;
    localparam logic [15:0] RST_MODE      = 16'h0000;

    // Setting ranges.
    localparam logic [15:0] THR_MAX       = 16'h270F;
    localparam logic [15:0] TC_MAX        = 16'h0064;
    localparam logic [15:0] POS_MIN       = 16'h0001;
    localparam logic [15:0] POS_MAX       = 16'h07D0;
    localparam logic [15:0] SPEED_MIN     = 16'h0014;
    localparam logic [15:0] SPEED_MAX     = 16'h4E20;
    localparam logic [15:0] INTEG_MIN     = 16'h0001;
    localparam logic [15:0] INTEG_MAX     = 16'hC350;
    localparam logic [15:0] FREQ_MIN      = 16'h0001;
    localparam logic [15:0] FREQ_MAX      = 16'h03E8;

    // Mode register fields and the manual settings they are compared with.
    localparam logic [3:0]  AUTO_TUNE_MANUAL = 4'h3;
    localparam logic [3:0]  VIB_TUNE_MANUAL  = 4'h2;
    localparam int unsigned MODE_SPEED_BIT   = 8;

    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    typedef enum logic [4:0] {
        SRC_OFF   = 5'b00001,
        SRC_CMD   = 5'b00010,
        SRC_FREQ  = 5'b00100,
        SRC_DROOP = 5'b01000,
        SRC_SPEED = 5'b10000
    } sgs_src_e;

    typedef struct packed {
        logic [15:0] inertia;
        logic [15:0] pos;
        logic [15:0] speed;
        logic [15:0] integ;
        logic [15:0] vib;
        logic [15:0] res;
    } sgs_gains_s;

    typedef logic [5:0][15:0] sgs_garr_t;

    function automatic sgs_src_e sgs_decode_src(input logic [3:0] digit);
        case (digit)
            4'h1:    sgs_decode_src = SRC_CMD;
            4'h2:    sgs_decode_src = SRC_FREQ;
            4'h3:    sgs_decode_src = SRC_DROOP;
            4'h4:    sgs_decode_src = SRC_SPEED;
            default: sgs_decode_src = SRC_OFF;
        endcase
    endfunction

    function automatic logic [15:0] sgs_clamp(input logic [15:0] v, input logic [15:0] lo,
                                              input logic [15:0] hi);
        sgs_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [15:0] sgs_merge(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] strb);
        sgs_merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    endfunction

endpackage

// ===== rtl/sgs_smooth.sv
// First-order smoothing stage that moves one gain toward its target.
module sgs_smooth #(
    parameter int unsigned W     = 16,
    parameter int unsigned SHIFT = 4
) (
    // Clock and reset.
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Control.
    input  wire logic         step,
    input  wire logic         bypass,
    input  wire logic [W-1:0] target,
    // Smoothed value.
    output logic      [W-1:0] value_reg
);
    logic signed [W:0] diff;
    logic signed [W:0] part;
    logic signed [W:0] delta;
    logic        [W-1:0] value_next;

    assign diff  = $signed({1'b0, target}) - $signed({1'b0, value_reg});
    assign part  = diff >>> SHIFT;
    // A remaining distance below one step still moves by one so the value lands exactly.
    assign delta = (part != '0) ? part : ((diff > 0) ? (W+1)'(1) : ((diff < 0) ? -(W+1)'(1) : '0));
    assign value_next = bypass ? target
                      : (step ? W'($signed({1'b0, value_reg}) + delta) : value_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value_reg <= '0;
        end else begin
            value_reg <= value_next;
        end
    end
endmodule // sgs_smooth

// ===== rtl/sgs_top.sv
// Gain-switching selector with its AXI4-Lite register file and gain blending.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
module sgs_top #(
    parameter int unsigned CYC_PER_MS = sgs_pkg::CYC_PER_MS
) (
    // Clock and reset.
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite write address and data.
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read.
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Loop state and controller command.
    input  wire logic                ctrl_gain_cmd,
    input  wire logic [31:0]         cmd_freq,
    input  wire logic [31:0]         droop_pulses,
    input  wire logic [31:0]         motor_speed,
    input  wire sgs_pkg::sgs_gains_s base_gains,
    // Gains to the loops.
    output sgs_pkg::sgs_gains_s      eff_gains,
    output logic                     switch_active_reg
);
    import sgs_pkg::*;

    logic [15:0]  select_reg;
    logic [15:0]  threshold_reg;
    logic [15:0]  time_const_reg;
    logic [15:0]  mode_reg;
    sgs_gains_s   alt_reg;
    logic [7:0]   awaddr_reg;
    logic [31:0]  wdata_reg;
    logic [3:0]   wstrb_reg;
    logic         aw_held_reg;
    logic         w_held_reg;
    logic [31:0]  step_cnt_reg;
    sgs_gains_s   target;
    sgs_garr_t    target_arr;
    sgs_garr_t    eff_arr;

    // Bus handshake.
    wire          aw_fire   = s_axi_awvalid && s_axi_awready;
    wire          w_fire    = s_axi_wvalid && s_axi_wready;
    wire          wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire          ar_fire   = s_axi_arvalid && s_axi_arready;
    wire [7:0]    wa        = awaddr_reg;
    wire          wa_mapped = (wa[1:0] == 2'b00) && (wa <= OFS_MODE);
    wire          ra_mapped = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= OFS_STATUS);

    // Condition evaluation.
    sgs_src_e     src;
    logic         polarity;
    logic [31:0]  measured;
    logic         at_or_above;
    logic         at_or_below;
    logic         cond;
    logic         core_en;
    logic         pos_en;
    logic         vib_en;
    logic         speed_mode;
    logic         settling;
    logic [31:0]  step_period;
    logic         step;
    logic         bypass;
    logic [31:0]  rd_mux;

    assign src         = sgs_decode_src(select_reg[3:0]);
    assign polarity    = select_reg[4];
    assign measured    = (src == SRC_FREQ)  ? cmd_freq
                       : (src == SRC_DROOP) ? droop_pulses
                       : motor_speed;
    assign at_or_above = measured >= {16'h0000, threshold_reg};
    assign at_or_below = measured <= {16'h0000, threshold_reg};
    always_comb begin
        case (src)
            SRC_OFF:   cond = 1'b0;
            SRC_CMD:   cond = polarity ? !ctrl_gain_cmd : ctrl_gain_cmd;
            SRC_FREQ,
            SRC_DROOP,
            SRC_SPEED: cond = polarity ? at_or_below : at_or_above;
            default:   cond = 1'b0;
        endcase
    end

    // Each alternate gain is gated by the tuning and control modes it depends on.
    assign speed_mode = mode_reg[MODE_SPEED_BIT];
    assign core_en    = cond && (mode_reg[3:0] == AUTO_TUNE_MANUAL);
    assign pos_en     = core_en && !speed_mode;
    // Vibration gains are only safe to change at standstill, which the controller ensures.
    assign vib_en     = cond && (mode_reg[7:4] == VIB_TUNE_MANUAL) && (src == SRC_CMD)
                        && !speed_mode;

    assign target.inertia = core_en ? alt_reg.inertia : base_gains.inertia;
    assign target.pos     = pos_en  ? alt_reg.pos     : base_gains.pos;
    assign target.speed   = core_en ? alt_reg.speed   : base_gains.speed;
    assign target.integ   = core_en ? alt_reg.integ   : base_gains.integ;
    assign target.vib     = vib_en  ? alt_reg.vib     : base_gains.vib;
    assign target.res     = vib_en  ? alt_reg.res     : base_gains.res;
    assign target_arr     = target;
    assign eff_gains      = eff_arr;
    assign settling       = (eff_gains != target);

    // Step period gives sixteen steps per time constant.
    assign step_period = 32'((time_const_reg * CYC_PER_MS) >> SMOOTH_SHIFT);
    assign bypass      = (time_const_reg == 16'h0000);
    assign step        = (step_cnt_reg + 32'h1 >= step_period);

    always_ff @(posedge aclk) begin
        if (!aresetn || bypass || step) begin
            step_cnt_reg <= 32'h0;
        end else begin
            step_cnt_reg <= step_cnt_reg + 32'h1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_smooth
            sgs_smooth #(
                .W     (16),
                .SHIFT (SMOOTH_SHIFT)
            ) u_smooth (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .step      (step),
                .bypass    (bypass),
                .target    (target_arr[gi]),
                .value_reg (eff_arr[gi])
            );
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            switch_active_reg <= 1'b0;
        end else begin
            switch_active_reg <= cond;
        end
    end

    // Write channel: address and data are taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 8'h00;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wa_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready  = !w_held_reg;

    // Register writes; values outside a setting range are clamped to it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            select_reg     <= RST_SELECT;
            threshold_reg  <= RST_THRESHOLD;
            time_const_reg <= RST_TIME;
            mode_reg       <= RST_MODE;
            alt_reg        <= '{RST_INERT, RST_POS, RST_SPEED, RST_INTEG, RST_VIB, RST_RES};
        end else if (wr_fire) begin
            case (wa)
                OFS_SELECT:     select_reg     <= sgs_merge(select_reg, wdata_reg, wstrb_reg)
                                                  & 16'h00FF;
                OFS_THRESHOLD:  threshold_reg  <= sgs_clamp(sgs_merge(threshold_reg, wdata_reg,
                                                  wstrb_reg), 16'h0000, THR_MAX);
                OFS_TIME_CONST: time_const_reg <= sgs_clamp(sgs_merge(time_const_reg, wdata_reg,
                                                  wstrb_reg), 16'h0000, TC_MAX);
                OFS_ALT_INERT:  alt_reg.inertia <= sgs_merge(alt_reg.inertia, wdata_reg,
                                                   wstrb_reg);
                OFS_ALT_POS:    alt_reg.pos   <= sgs_clamp(sgs_merge(alt_reg.pos, wdata_reg,
                                                 wstrb_reg), POS_MIN, POS_MAX);
                OFS_ALT_SPEED:  alt_reg.speed <= sgs_clamp(sgs_merge(alt_reg.speed, wdata_reg,
                                                 wstrb_reg), SPEED_MIN, SPEED_MAX);
                OFS_ALT_INTEG:  alt_reg.integ <= sgs_clamp(sgs_merge(alt_reg.integ, wdata_reg,
                                                 wstrb_reg), INTEG_MIN, INTEG_MAX);
                OFS_ALT_VIB:    alt_reg.vib   <= sgs_clamp(sgs_merge(alt_reg.vib, wdata_reg,
                                                 wstrb_reg), FREQ_MIN, FREQ_MAX);
                OFS_ALT_RES:    alt_reg.res   <= sgs_clamp(sgs_merge(alt_reg.res, wdata_reg,
                                                 wstrb_reg), FREQ_MIN, FREQ_MAX);
                OFS_MODE:       mode_reg      <= sgs_merge(mode_reg, wdata_reg, wstrb_reg)
                                                 & 16'h01FF;
                default:        mode_reg      <= mode_reg;
            endcase
        end
    end

    // Read channel.
    always_comb begin
        case (s_axi_araddr)
            OFS_SELECT:     rd_mux = {16'h0000, select_reg};
            OFS_THRESHOLD:  rd_mux = {16'h0000, threshold_reg};
            OFS_TIME_CONST: rd_mux = {16'h0000, time_const_reg};
            OFS_ALT_INERT:  rd_mux = {16'h0000, alt_reg.inertia};
            OFS_ALT_POS:    rd_mux = {16'h0000, alt_reg.pos};
            OFS_ALT_SPEED:  rd_mux = {16'h0000, alt_reg.speed};
            OFS_ALT_INTEG:  rd_mux = {16'h0000, alt_reg.integ};
            OFS_ALT_VIB:    rd_mux = {16'h0000, alt_reg.vib};
            OFS_ALT_RES:    rd_mux = {16'h0000, alt_reg.res};
            OFS_MODE:       rd_mux = {16'h0000, mode_reg};
            OFS_STATUS:     rd_mux = {29'h0, settling, cond, switch_active_reg};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= ra_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // sgs_top
